// ==== hw/pcm_pkg.sv ====
/*
  Constants shared by the PLL tuning and clock mux select block: register
  offsets, configuration word bit positions, reset values and bus responses.
  Assumes a 128-bit configuration word held as four 32-bit register words.
*/
`default_nettype none

package pcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int unsigned CFG_BITS   = 128;
  localparam int unsigned CFG_WORDS  = 4;
  localparam logic [7:0]  OFS_CFG0   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions in the configuration word
  localparam int unsigned BIT_MUX_A_LSB                 = 22;
  localparam int unsigned BIT_MUX_B_LSB                 = 46;
  localparam int unsigned BIT_PLL_A_FILTER_CONST        = 20;
  localparam int unsigned BIT_PLL_B_FILTER_CONST        = 44;
  localparam int unsigned BIT_PLL_C_FILTER_CONST_SET1   = 68;
  localparam int unsigned BIT_PLL_C_FILTER_CONST_SET2   = 92;
  localparam int unsigned BIT_PLL_A_PUMP_CURRENT        = 19;
  localparam int unsigned BIT_PLL_B_PUMP_CURRENT        = 43;
  localparam int unsigned BIT_PLL_C_PUMP_CURRENT_SET1   = 67;
  localparam int unsigned BIT_PLL_C_PUMP_CURRENT_SET2   = 91;

  ////////////////////////////////////////////////////////////////////////////
  // Status register bit positions
  localparam int unsigned ST_SET_ACTIVE   = 0;
  localparam int unsigned ST_C_FILTER     = 1;
  localparam int unsigned ST_C_PUMP       = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and responses
  localparam logic [127:0] RST_CFG     = 128'h0;
  localparam logic [1:0]   RESP_OKAY   = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PCM_SRC_REF   = 2'h0,
    PCM_SRC_PLL_A = 2'h1,
    PCM_SRC_PLL_B = 2'h2,
    PCM_SRC_PLL_C = 2'h3
  } pcm_src_e;

endpackage

`default_nettype wire

// ==== hw/pcm_pin_sync.sv ====
/*
  Three-stage synchroniser with agreement filter for an asynchronous pin.
  Assumes the pin is a slow level; a change counts once stages two and three agree.
*/
`timescale 1ns/10ps
`default_nettype none

module pcm_pin_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_async,
  output var  logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } pcm_sync_s;

  pcm_sync_s q;
  pcm_sync_s next_q;

  always_comb begin
    next_q    = q;
    next_q.s1 = pin_async;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (q.s2 == q.s3) begin
      next_q.level = q.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;

  a_sync_agree: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(level) |-> ($past(q.s2) == $past(q.s3)))
    else $error("Pin level changed without stage agreement");

endmodule

`default_nettype wire

// ==== hw/pcm_cfg_regs.sv ====
/*
  Configuration storage and decode for PLL tuning and output muxes A and B,
  reached over an AXI4-Lite slave. Holds the 128-bit configuration word as
  four words and drives the decoded tuning and mux selects from flip-flops.
  Assumes one clock, synchronous active-low reset, an asynchronous set pin.
*/
// The register offsets and register access over AXI4-Lite were left to the implementer.
// Notes on behaviour
// - Mux A bits 23-22, B bits 47-46: 00 ref, 01 PLL A, 10 PLL B, 11 PLL C.
// - Filter bits 20 (A) and 44 (B): clear short 7us, set long 20us.
// - PLL C filter: bit 68 first set, bit 92 second, chosen by set pin.
// - Pump bits 19 (A) and 43 (B): clear 2uA, set 10uA.
// - PLL C pump: bit 67 while set pin low, bit 91 while high.
`timescale 1ns/10ps
`default_nettype none

module pcm_cfg_regs #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  input  wire logic              tuning_set_select_pin,
  output var  pcm_pkg::pcm_src_e mux_a_sel,
  output var  pcm_pkg::pcm_src_e mux_b_sel,
  output var  logic              pll_a_filter_const,
  output var  logic              pll_b_filter_const,
  output var  logic              pll_c_filter_const,
  output var  logic              pll_a_pump_current,
  output var  logic              pll_b_pump_current,
  output var  logic              pll_c_pump_current,
  output var  logic              pll_c_set_active
);

  typedef struct packed {
    logic [127:0]      cfg;
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    pcm_pkg::pcm_src_e mux_a;
    pcm_pkg::pcm_src_e mux_b;
    logic              a_filter;
    logic              b_filter;
    logic              c_filter;
    logic              a_pump;
    logic              b_pump;
    logic              c_pump;
    logic              c_set;
    logic              live;
  } pcm_regs_s;

  pcm_regs_s q;
  pcm_regs_s next_q;
  logic      set_active;
  logic      wr_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Set select pin crossing

  pcm_pin_sync u_set_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_async (tuning_set_select_pin),
    .level     (set_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave, storage and decode

  assign wr_fire = q.aw_held && q.w_held && !q.bvalid;

  always_comb begin
    logic [ADDR_W-1:0] ra;
    logic [6:0]        base;
    logic              wmap;
    ra     = araddr;
    base   = 7'h0;
    wmap   = 1'b0;
    next_q = q;
    next_q.live = 1'b1;

    // Address and data are caught independently, in either order
    if (awvalid && q.awready) begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      next_q.w_held = 1'b1;
      next_q.w_data = wdata;
      next_q.w_strb = wstrb;
    end

    if (bvalid && bready) begin
      next_q.bvalid = 1'b0;
    end

    // Configuration changes only here, under a completed bus write
    if (wr_fire) begin
      wmap = (q.aw_addr[ADDR_W-1:4] == '0);
      base = {q.aw_addr[3:2], 5'h0};
      if (wmap) begin
        for (int b = 0; b < 4; b++) begin
          if (q.w_strb[b]) begin
            next_q.cfg[base + 7'(b * 8) +: 8] = q.w_data[b*8 +: 8];
          end
        end
      end
      next_q.aw_held = 1'b0;
      next_q.w_held  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = wmap ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
    end

    next_q.awready = !next_q.aw_held && !next_q.bvalid;
    next_q.wready  = !next_q.w_held && !next_q.bvalid;

    if (rvalid && rready) begin
      next_q.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = pcm_pkg::RESP_OKAY;
      next_q.rdata  = 32'h0;
      if (ra[ADDR_W-1:4] == '0) begin
        next_q.rdata = q.cfg[{ra[3:2], 5'h0} +: 32];
      end else if (ra == ADDR_W'(pcm_pkg::OFS_STATUS)) begin
        next_q.rdata[pcm_pkg::ST_SET_ACTIVE] = q.c_set;
        next_q.rdata[pcm_pkg::ST_C_FILTER]   = q.c_filter;
        next_q.rdata[pcm_pkg::ST_C_PUMP]     = q.c_pump;
      end else begin
        next_q.rresp = pcm_pkg::RESP_SLVERR;
      end
    end
    next_q.arready = !next_q.rvalid;

    // Decode of the held word
    next_q.mux_a    = pcm_pkg::pcm_src_e'(q.cfg[pcm_pkg::BIT_MUX_A_LSB +: 2]);
    next_q.mux_b    = pcm_pkg::pcm_src_e'(q.cfg[pcm_pkg::BIT_MUX_B_LSB +: 2]);
    next_q.a_filter = q.cfg[pcm_pkg::BIT_PLL_A_FILTER_CONST];
    next_q.b_filter = q.cfg[pcm_pkg::BIT_PLL_B_FILTER_CONST];
    next_q.a_pump   = q.cfg[pcm_pkg::BIT_PLL_A_PUMP_CURRENT];
    next_q.b_pump   = q.cfg[pcm_pkg::BIT_PLL_B_PUMP_CURRENT];
    // PLL C follows the pin with no register action
    next_q.c_set    = set_active;
    next_q.c_filter = set_active ? q.cfg[pcm_pkg::BIT_PLL_C_FILTER_CONST_SET2]
                                 : q.cfg[pcm_pkg::BIT_PLL_C_FILTER_CONST_SET1];
    next_q.c_pump   = set_active ? q.cfg[pcm_pkg::BIT_PLL_C_PUMP_CURRENT_SET2]
                                 : q.cfg[pcm_pkg::BIT_PLL_C_PUMP_CURRENT_SET1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.cfg     <= pcm_pkg::RST_CFG;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign awready            = q.awready;
  assign wready             = q.wready;
  assign bvalid             = q.bvalid;
  assign bresp              = q.bresp;
  assign arready            = q.arready;
  assign rvalid             = q.rvalid;
  assign rdata              = q.rdata;
  assign rresp              = q.rresp;
  assign mux_a_sel          = q.mux_a;
  assign mux_b_sel          = q.mux_b;
  assign pll_a_filter_const = q.a_filter;
  assign pll_b_filter_const = q.b_filter;
  assign pll_c_filter_const = q.c_filter;
  assign pll_a_pump_current = q.a_pump;
  assign pll_b_pump_current = q.b_pump;
  assign pll_c_pump_current = q.c_pump;
  assign pll_c_set_active   = q.c_set;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  // Checks start one edge after reset so $past never sees pre-reset values
  default disable iff (!aresetn || !q.live);

  a_mux_a_route: assert property (
    $past(wr_fire, 2) && $past(q.aw_addr, 2) == '0 && $past(q.w_strb[2], 2)
    |=> mux_a_sel == pcm_pkg::pcm_src_e'($past(q.w_data[23:22], 3)))
    else $error("Mux A select does not follow written bits");

  a_mux_b_route: assert property (
    !$past(wr_fire) |-> mux_b_sel == pcm_pkg::pcm_src_e'($past(q.cfg[47:46])))
    else $error("Mux B select does not follow stored bits");

  a_filter_a_b: assert property (
    pll_a_filter_const == $past(q.cfg[20]) && pll_b_filter_const == $past(q.cfg[44]))
    else $error("PLL A or B filter constant wrong");

  a_pump_a_b: assert property (
    pll_a_pump_current == $past(q.cfg[19]) && pll_b_pump_current == $past(q.cfg[43]))
    else $error("PLL A or B pump current wrong");

  a_c_filter_sel: assert property (
    pll_c_filter_const == ($past(set_active) ? $past(q.cfg[92]) : $past(q.cfg[68])))
    else $error("PLL C filter constant from wrong set");

  a_c_pump_low: assert property (
    !pll_c_set_active |-> pll_c_pump_current == $past(q.cfg[67]))
    else $error("PLL C pump not from first set");

  a_c_pump_high: assert property (
    pll_c_set_active |-> pll_c_pump_current == $past(q.cfg[91]))
    else $error("PLL C pump not from second set");

  a_cfg_hold: assert property (
    !wr_fire |=> $stable(q.cfg))
    else $error("Configuration changed without a write");

  a_pin_switch: assert property (
    $rose(set_active) && !wr_fire |=> pll_c_set_active ##0
    pll_c_pump_current == $past(q.cfg[91]))
    else $error("Set pin did not switch PLL C");

endmodule

`default_nettype wire

// ==== verification/pcm_host_model.sv ====
/*
  Serial host stand-in for the PLL tuning block: AXI4-Lite master tasks and
  a builder that packs tuning and mux fields into the configuration word.
  Assumes one clock; tasks are called from one process at a time.
*/
`timescale 1ns/10ps
`default_nettype none

module pcm_host_model (
  input  wire logic        aclk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    input logic [3:0] s = 4'hf);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      // Released payload is scrambled so nothing leans on a stale value
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Fields t: filter A, B, C1, C2, pump A, B, C1, C2 from msb down
  task automatic set_cfg(input logic [1:0] ma, input logic [1:0] mb, input logic [7:0] t);
    logic [127:0] c;
    logic [1:0]   r;
    c = '0;
    c[pcm_pkg::BIT_MUX_A_LSB +: 2] = ma;
    c[pcm_pkg::BIT_MUX_B_LSB +: 2] = mb;
    c[pcm_pkg::BIT_PLL_A_FILTER_CONST] = t[7];
    c[pcm_pkg::BIT_PLL_B_FILTER_CONST] = t[6];
    c[pcm_pkg::BIT_PLL_C_FILTER_CONST_SET1] = t[5];
    c[pcm_pkg::BIT_PLL_C_FILTER_CONST_SET2] = t[4];
    c[pcm_pkg::BIT_PLL_A_PUMP_CURRENT] = t[3];
    c[pcm_pkg::BIT_PLL_B_PUMP_CURRENT] = t[2];
    c[pcm_pkg::BIT_PLL_C_PUMP_CURRENT_SET1] = t[1];
    c[pcm_pkg::BIT_PLL_C_PUMP_CURRENT_SET2] = t[0];
    for (int i = 0; i < 4; i++) wr(8'(4 * i), c[32 * i +: 32], r);
  endtask
endmodule

`default_nettype wire

// ==== verification/pll_tuning_and_clock_mux_select_test.sv ====
/*
  Self-checking bench for pcm_cfg_regs: reset, table of settings, readback,
  pin-only switching, refused accesses, a strobed write and a second reset.
  Assumes pcm_host_model as the bus master.
*/
`timescale 1ns/10ps
`default_nettype none

module pll_tuning_and_clock_mux_select_test;
  typedef struct packed {
    logic [1:0] ma;
    logic [1:0] mb;
    logic [7:0] t;
    logic       pin;
    logic       efc;
    logic       epc;
  } pcm_row_s;

  logic              aclk, aresetn, tuning_set_select_pin;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r;
  logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  pcm_pkg::pcm_src_e mux_a_sel, mux_b_sel;
  logic              pll_a_filter_const, pll_b_filter_const, pll_c_filter_const, pll_c_set_active;
  logic              pll_a_pump_current, pll_b_pump_current, pll_c_pump_current;
  wire logic [10:0]  outs = {mux_a_sel, mux_b_sel, pll_a_filter_const, pll_b_filter_const, pll_c_filter_const,
                             pll_a_pump_current, pll_b_pump_current, pll_c_pump_current, pll_c_set_active};
  int                errors, samples_checked, cycles;
  logic [31:0]       rb [4] = '{32'h00c80000, 32'h00005000, 32'h10000008, 32'h0};
  pcm_row_s          rows [5] = '{'{2'h0, 2'h3, 8'ha5, 1'b0, 1'b1, 1'b0}, '{2'h1, 2'h2, 8'h5a, 1'b1, 1'b1, 1'b0},
                                  '{2'h2, 2'h1, 8'h5a, 1'b0, 1'b0, 1'b1}, '{2'h3, 2'h0, 8'hff, 1'b1, 1'b1, 1'b1},
                                  '{2'h0, 2'h0, 8'h00, 1'b1, 1'b0, 1'b0}};

  pcm_host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
                       .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  pcm_cfg_regs DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
                    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
                    .tuning_set_select_pin, .mux_a_sel, .mux_b_sel, .pll_a_filter_const, .pll_b_filter_const,
                    .pll_c_filter_const, .pll_a_pump_current, .pll_b_pump_current, .pll_c_pump_current,
                    .pll_c_set_active);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    tuning_set_select_pin = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(outs), 32'h0);
    foreach (rows[i]) begin
      tuning_set_select_pin <= rows[i].pin;
      host.set_cfg(rows[i].ma, rows[i].mb, rows[i].t);
      repeat (8) @(posedge aclk);
      chk(32'(outs), 32'({rows[i].ma, rows[i].mb, rows[i].t[7:6], rows[i].efc, rows[i].t[3:2], rows[i].epc,
                           rows[i].pin}));
    end
    host.set_cfg(2'h3, 2'h1, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      host.rd(8'(4 * i), d, r);
      chk(d, rb[i]);
    end
    // Pin alone swaps the PLL C set
    tuning_set_select_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(32'(outs), 32'h6aa);
    tuning_set_select_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(outs), 32'h6b9);
    host.wr(pcm_pkg::OFS_STATUS, 32'hffffffff, r);
    chk(32'(r), 32'(pcm_pkg::RESP_SLVERR));
    host.rd(pcm_pkg::OFS_STATUS, d, r);
    chk(d, 32'h3);
    host.rd(8'h14, d, r);
    chk({d[29:0], r}, 32'(pcm_pkg::RESP_SLVERR));
    repeat (2) @(posedge aclk);
    chk(32'(outs), 32'h6b9);
    // Only the strobed byte may land
    host.wr(pcm_pkg::OFS_CFG0, 32'hff40ffff, r, 4'h4);
    chk(32'(r), 32'(pcm_pkg::RESP_OKAY));
    repeat (2) @(posedge aclk);
    chk(32'(outs), 32'h2b1);
    host.rd(pcm_pkg::OFS_CFG0, d, r);
    chk(d, 32'h00400000);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(outs), 32'h0);
    host.rd(pcm_pkg::OFS_CFG0, d, r);
    chk(d, pcm_pkg::RST_CFG[31:0]);
    final_report();
  end
endmodule

`default_nettype wire
